// ==== sdadc_host.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_host_regs.svh"
module sdadc_host
   import sdadc_host_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout_rdy
);
   // ****************************************
   // Shared-line input filter.
   // ****************************************
   logic s1_q, s2_q, s3_q, rdy_q;
   logic s1_d, s2_d, s3_d, rdy_d;

   // The line is accepted only once the last two stages agree, which hides a
   // metastable or glitching first stage from the sequencer.
   always_comb begin
      s1_d = dout_rdy;
      s2_d = s1_q;
      s3_d = s2_q;
      rdy_d = (s2_q == s3_q) ? s3_q : rdy_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         rdy_q <= 1'b1;
      end else if (ce) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         rdy_q <= rdy_d;
      end
   end

   // ****************************************
   // Registers and frame sequencer.
   // ****************************************
   state_t state_q, state_d;
   logic three_wire_q, three_wire_d;
   logic [31:0] wbuf_q, wbuf_d;
   logic [31:0] tx_q, tx_d;
   logic [31:0] rx_q, rx_d;
   logic [23:0] res_q, res_d;
   logic [1:0] nb_q, nb_d;
   logic [5:0] cnt_q, cnt_d;
   logic [5:0] total_q, total_d;
   logic [2:0] div_q, div_d;
   logic wait_q, wait_d;
   logic ifrst_q, ifrst_d;
   logic done_q, done_d;
   logic cs_n_q, cs_n_d;
   logic sclk_q, sclk_d;
   logic din_q, din_d;
   logic [31:0] rdata_q, rdata_d;
   logic start;
   logic [1:0] c_nb;
   logic c_skip;
   logic c_rst;
   logic [5:0] c_total;
   logic [23:0] c_data;
   logic [4:0] c_sh;

   assign c_nb = wdata[`CMD_NB_HI:`CMD_NB_LO];
   assign c_skip = wdata[`CMD_SKIP];
   assign c_rst = wdata[`CMD_IFRST];
   assign c_sh = 5'(`NB_SHIFT * (5'h3 - {3'h0, c_nb}));
   assign c_data = wbuf_q[23:0] << c_sh;
   // The interface reset is a plain run of ones; a command byte is prepended
   // to everything else unless continuous read lets the host skip it.
   assign c_total = c_rst ? `RESET_ONES :
      6'((c_skip ? `CNT_ZERO : `COMM_BITS) + `BYTE_BITS * {4'h0, c_nb});
   // Commands arriving while busy, or with nothing to shift, are dropped.
   assign start = wr && (addr == `ADDR_CMD) && (state_q == ST_IDLE) &&
      (c_total != `CNT_ZERO);

   // Next state of the bus registers and of the serial frame.
   always_comb begin
      state_d = state_q;
      three_wire_d = three_wire_q;
      wbuf_d = wbuf_q;
      tx_d = tx_q;
      rx_d = rx_q;
      res_d = res_q;
      nb_d = nb_q;
      cnt_d = cnt_q;
      total_d = total_q;
      div_d = div_q;
      wait_d = wait_q;
      ifrst_d = ifrst_q;
      done_d = done_q;
      cs_n_d = cs_n_q;
      sclk_d = sclk_q;
      din_d = din_q;
      rdata_d = `ZERO32;
      // Reading status clears the done flag; a completion in the same cycle
      // sets it again further down, so the event is never lost.
      if (rd) begin
         case (addr)
            `ADDR_CTRL: rdata_d = {31'h0, three_wire_q};
            `ADDR_WDATA: rdata_d = wbuf_q;
            `ADDR_RDATA: rdata_d = {8'h00, res_q};
            `ADDR_STAT: begin
               rdata_d = {29'h0, done_q, rdy_q, state_q != ST_IDLE};
               done_d = 1'b0;
            end
            default: rdata_d = `ZERO32;
         endcase
      end
      if (wr && addr == `ADDR_CTRL) begin
         three_wire_d = wdata[`CTRL_THREE_WIRE];
      end
      if (wr && addr == `ADDR_WDATA) begin
         wbuf_d = wdata;
      end
      case (state_q)
         ST_IDLE: begin
            sclk_d = 1'b1;
            din_d = 1'b0;
            if (start) begin
               // Unless skipped or a reset, the command byte leads, then the data bytes, MSB first.
               if (c_rst) begin
                  tx_d = `ONES32;
               end else if (c_skip) begin
                  tx_d = {c_data, 8'h00};
               end else begin
                  tx_d = {wdata[`CMD_COMM_HI:`CMD_COMM_LO], c_data};
               end
               nb_d = c_nb;
               total_d = c_total;
               ifrst_d = c_rst;
               wait_d = wdata[`CMD_WAIT] && !c_rst;
               cnt_d = `CNT_ZERO;
               div_d = `DIV_ZERO;
               rx_d = `ZERO32;
               cs_n_d = 1'b0;
               state_d = (wdata[`CMD_WAIT] && !c_rst) ? ST_WAIT : ST_SHIFT;
            end
         end
         ST_WAIT: begin
            // Starting right as ready falls leaves the most time before the
            // next update overwrites the word.
            if (!rdy_q) begin
               div_d = `DIV_ZERO;
               state_d = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            // The clock runs only inside the frame; the device would accept
            // a free-running one too.
            div_d = div_q + `DIV_ONE;
            if (div_q == `SCLK_HALF - `DIV_ONE) begin
               div_d = `DIV_ZERO;
               sclk_d = !sclk_q;
               if (sclk_q) begin
                  din_d = tx_q[31];
                  tx_d = {tx_q[30:0], 1'b0};
               end else begin
                  // The synchroniser's agreeing stages already hold the bit that
                  // the device launched at the fall half a period ago. The
                  // registered level would still show the bit before it.
                  rx_d = {rx_q[30:0], rdy_d};
                  cnt_d = cnt_q + `CNT_ONE;
                  if (cnt_q + `CNT_ONE == total_q) begin
                     state_d = ST_GAP;
                  end
               end
            end
         end
         ST_GAP: begin
            din_d = 1'b0;
            cs_n_d = 1'b1;
            div_d = div_q + `DIV_ONE;
            if (div_q == `SCLK_HALF - `DIV_ONE) begin
               div_d = `DIV_ZERO;
               done_d = 1'b1;
               state_d = ST_IDLE;
               case (nb_q)
                  2'h1: res_d = {16'h0000, rx_q[7:0]};
                  2'h2: res_d = {8'h00, rx_q[15:0]};
                  2'h3: res_d = rx_q[23:0];
                  default: res_d = res_q;
               endcase
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // Three-line mode ties the select low for good.
      if (three_wire_d) begin
         cs_n_d = 1'b0;
      end else if (state_d == ST_IDLE) begin
         cs_n_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         three_wire_q <= 1'b0;
         wbuf_q <= `ZERO32;
         tx_q <= `ZERO32;
         rx_q <= `ZERO32;
         res_q <= 24'h000000;
         nb_q <= 2'h0;
         cnt_q <= `CNT_ZERO;
         total_q <= `CNT_ZERO;
         div_q <= `DIV_ZERO;
         wait_q <= 1'b0;
         ifrst_q <= 1'b0;
         done_q <= 1'b0;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b1;
         din_q <= 1'b0;
         rdata_q <= `ZERO32;
      end else if (ce) begin
         state_q <= state_d;
         three_wire_q <= three_wire_d;
         wbuf_q <= wbuf_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         res_q <= res_d;
         nb_q <= nb_d;
         cnt_q <= cnt_d;
         total_q <= total_d;
         div_q <= div_d;
         wait_q <= wait_d;
         ifrst_q <= ifrst_d;
         done_q <= done_d;
         cs_n_q <= cs_n_d;
         sclk_q <= sclk_d;
         din_q <= din_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;
   assign cs_n = cs_n_q;
   assign sclk = sclk_q;
   assign din = din_q;

   // ****************************************
   // Checks.
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   sequence s_leave_wait;
      state_q == ST_WAIT ##1 state_q == ST_SHIFT;
   endsequence

   sequence s_cmd_start;
      start && !c_rst && !c_skip;
   endsequence

   comm_byte_first_a: assert property (s_cmd_start |=> tx_q[31:24] == $past(wdata[7:0]))
      else $error("Command byte not loaded at the head of the frame.");
   sclk_idle_high_a: assert property (state_q == ST_IDLE |-> sclk_q)
      else $error("Serial clock not high while idle.");
   din_on_fall_a: assert property ($changed(din_q) && state_q == ST_SHIFT |-> !sclk_q)
      else $error("Data input changed outside the falling edge.");
   frame_select_a: assert property (state_q inside {ST_WAIT, ST_SHIFT} |-> !cs_n_q)
      else $error("Chip select high during a frame.");
   three_line_a: assert property (three_wire_q && $stable(three_wire_q) |-> !cs_n_q)
      else $error("Chip select released in three-line mode.");
   reset_ones_a: assert property (ifrst_q && state_q == ST_SHIFT && !sclk_q |-> din_q)
      else $error("Interface reset frame sent a zero.");
   wait_ready_a: assert property (s_leave_wait |-> $past(rdy_q) == 1'b0)
      else $error("Frame began before ready went low.");
   bit_count_a: assert property (state_q == ST_SHIFT |-> cnt_q < total_q)
      else $error("Bit count ran past the frame length.");
   frame_end_a: assert property (state_q == ST_SHIFT ##1 state_q == ST_GAP
      |-> cnt_q == total_q ##[1:4] state_q == ST_IDLE && done_q)
      else $error("Frame did not close with the right count.");
endmodule
`default_nettype wire

// ==== sdadc_host_regs.svh ====
`ifndef SDADC_HOST_REGS_SVH
`define SDADC_HOST_REGS_SVH
// ****************************************
// Register map of the host controller.
// ****************************************
`define ADDR_CTRL 8'h00
`define ADDR_CMD 8'h04
`define ADDR_WDATA 8'h08
`define ADDR_RDATA 8'h0C
`define ADDR_STAT 8'h10
// Control register fields.
`define CTRL_THREE_WIRE 0
`define CTRL_RESET 32'h0000_0000
// Command register fields.
`define CMD_COMM_HI 7
`define CMD_COMM_LO 0
`define CMD_NB_HI 9
`define CMD_NB_LO 8
`define CMD_READ 10
`define CMD_SKIP 11
`define CMD_IFRST 12
`define CMD_WAIT 13
// Status register fields.
`define STAT_BUSY 0
`define STAT_RDY 1
`define STAT_DONE 2
// ****************************************
// Link timing and counts.
// ****************************************
`define SCLK_HALF 3'h4
`define DIV_ZERO 3'h0
`define DIV_ONE 3'h1
`define RESET_ONES 6'h20
`define COMM_BITS 6'h08
`define BYTE_BITS 6'h08
`define CNT_ZERO 6'h00
`define CNT_ONE 6'h01
`define NB_SHIFT 5'h08
`define ZERO32 32'h0000_0000
`define ONES32 32'hFFFF_FFFF
`endif

// ==== sdadc_host_pkg.sv ====
`default_nettype none
package sdadc_host_pkg;
   // Sequencer states of the serial host.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_SHIFT = 2'b10,
      ST_GAP = 2'b11
   } state_t;
endpackage
`default_nettype wire

// ==== sdadc_dev_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********************
// Converter model on the far side of the link.
// ********************
module sdadc_dev_model #(
   parameter int RWB = 3,
   parameter int RSL = 4
) (
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic conv,
   input wire logic [23:0] conv_val,
   output logic dout_rdy
);
   logic [7:0] sh_in, filt_q;
   logic [23:0] data_q, sh_out;
   logic [1:0] rs;
   logic rdy_n, cont, drv;
   logic outb = 1'b1;
   int ph, nb, nc, ones, w;
   // Power-on state, also entered by the serial reset.
   task automatic por();
      ph = 0;
      nb = 0;
      ones = 0;
      cont = 0;
      drv = 0;
      rdy_n = 1;
      filt_q = 8'h04;
      data_q = 24'h0;
   endtask
   initial por();
   // Deselected, the line floats up to its pull-up level.
   assign dout_rdy = cs_n ? 1'b1 : ((ph == 2 || drv) ? outb : rdy_n);
   // Capture on rising edges; a long run of ones wipes the interface.
   always @(posedge sclk) begin
      if (!cs_n) begin
         ones = din ? ones + 1 : 0;
         sh_in = {sh_in[6:0], din};
         nb = nb + 1;
         if (cont && drv) begin
            nc = nc + 1;
            rdy_n = (nc == 24) ? 1'b1 : rdy_n;
            drv = (nc != 24);
         end
         if (ones >= 32) begin
            por();
         end else if (ph == 0 && nb == 8) begin
            nb = 0;
            rs = sh_in[RSL+:2];
            if (sh_in[7:1] == 7'h1E) begin
               cont = 1;
            end else if (!cont || (sh_in[7:2] == 6'h0E && !rdy_n)) begin
               cont = 0;
               drv = 0;
               w = (rs == 2'd3) ? 24 : 8;
               ph = sh_in[RWB] ? 2 : ((rs == 2'd0) ? 0 : 1);
               sh_out = (rs == 2'd3) ? data_q : {(rs == 2'd2) ? filt_q : {rdy_n, 7'h0}, 16'h0};
            end
         end else if (ph != 0 && nb == w) begin
            filt_q = (ph == 1 && rs == 2'd2) ? sh_in : filt_q;
            rdy_n = (ph == 2 && rs == 2'd3) ? 1'b1 : rdy_n;
            ph = 0;
            nb = 0;
         end
      end
   end
   // Launch on falling edges so a bit is steady at the host's rising sample.
   always @(negedge sclk) begin
      if (!cs_n && (ph == 2 || (cont && !rdy_n))) begin
         outb = sh_out[23];
         sh_out = {sh_out[22:0], 1'b0};
         drv = cont;
      end
   end
   // A select used as frame sync shows the pending first bit before any clock
   // edge; the first falling edge then presents that same bit again.
   always @(negedge cs_n) begin
      if (cont && !rdy_n) begin
         outb = sh_out[23];
         drv = 1;
      end
   end
   // A new result: the line goes high over the update, low once it has landed.
   always @(posedge conv) begin
      rdy_n = 1;
      #20;
      data_q = conv_val;
      nc = 0;
      sh_out = cont ? conv_val : sh_out;
      rdy_n = 0;
   end
endmodule
`default_nettype wire

// ==== sdadc_host_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "sdadc_host_regs.svh"
// ********************
// Host controller against the converter model.
// ********************
module sdadc_host_bench;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, conv = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [23:0] conv_val = 24'h0;
   logic [31:0] rdata, got, v, r;
   logic cs_n, sclk, din, dout_rdy;
   integer seed = 32'h74FF, n_errors = 0, checks_done = 0, cyc = 0;
   sdadc_host uut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .cs_n(cs_n), .sclk(sclk), .din(din), .dout_rdy(dout_rdy));
   sdadc_dev_model dev (.cs_n(cs_n), .sclk(sclk), .din(din), .conv(conv),
      .conv_val(conv_val), .dout_rdy(dout_rdy));
   // Free-running system clock.
   always #5 clk = ~clk;
   // Watchdog, so a lost handshake still ends in a verdict.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: timeout", $time);
         results();
      end
   end
   // Closing report.
   task automatic results();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Compare one value; an unknown never matches.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done = checks_done + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // Bus cycles: one-cycle strobes, read data taken in the cycle after.
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Command word: byte, data bytes, skip and wait flags.
   function automatic logic [31:0] cw(input logic [7:0] c, input logic [1:0] n,
      input logic s, input logic w);
      cw = `ZERO32;
      cw[`CMD_COMM_HI:`CMD_COMM_LO] = c;
      cw[`CMD_NB_HI:`CMD_NB_LO] = n;
      cw[`CMD_READ] = c[3];
      cw[`CMD_SKIP] = s;
      cw[`CMD_WAIT] = w;
   endfunction
   // One frame, polled to completion under a bound.
   task automatic cmd(input logic [31:0] c, input logic [31:0] d);
      wreg(`ADDR_WDATA, d);
      wreg(`ADDR_CMD, c);
      for (int j = 0; j < 400 && v[`STAT_DONE] !== 1'b1; j++) begin
         rreg(`ADDR_STAT, v);
      end
      chk({31'h0, v[`STAT_DONE]}, 32'h1);
      v = `ZERO32;
   endtask
   task automatic frame_rd(input logic [31:0] c, input logic [31:0] e);
      cmd(c, `ZERO32);
      rreg(`ADDR_RDATA, got);
      chk(got, e);
   endtask
   // Post a result and wait, bounded, for ready to reach status.
   task automatic cnv(input logic [23:0] d);
      @(posedge clk);
      conv_val <= d;
      conv <= 1'b1;
      @(posedge clk);
      conv <= 1'b0;
      // Start from a not-ready value so the poll really reads status.
      v = `ONES32;
      for (int j = 0; j < 50 && v[`STAT_RDY] !== 1'b0; j++) begin
         rreg(`ADDR_STAT, v);
      end
      chk({31'h0, v[`STAT_RDY]}, 32'h0);
      v = `ZERO32;
   endtask
   // Main sequence.
   initial begin
      v = `ZERO32;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk({29'h0, cs_n, sclk, din}, 32'h6);
      rreg(8'hFC, got);
      chk(got, `ZERO32);
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         r = {24'h0, 2'b00, k[1:0], 1'b0, r[2:0]};
         cmd(cw(8'h20, 2'd1, 1'b0, 1'b0), r);
         frame_rd(cw(8'h28, 2'd1, 1'b0, 1'b0), r);
         chk({31'h0, cs_n}, 32'h1);
      end
      wreg(`ADDR_CTRL, 32'h1);
      r = $random(seed);
      cnv(r[23:0]);
      frame_rd(cw(8'h38, 2'd3, 1'b0, 1'b1), {8'h0, r[23:0]});
      rreg(`ADDR_STAT, v);
      chk({31'h0, v[`STAT_RDY]}, 32'h1);
      frame_rd(cw(8'h38, 2'd3, 1'b0, 1'b0), {8'h0, r[23:0]});
      chk({31'h0, cs_n}, 32'h0);
      cmd(32'h1 << `CMD_IFRST, `ZERO32);
      frame_rd(cw(8'h28, 2'd1, 1'b0, 1'b0), 32'h4);
      for (int k = 0; k < 2; k++) begin
         cmd(cw(8'h3C + k[7:0], 2'd0, 1'b0, 1'b0), `ZERO32);
         r = $random(seed);
         cnv(r[23:0]);
         frame_rd(cw(8'h00, 2'd3, 1'b1, 1'b1), {8'h0, r[23:0]});
         rreg(`ADDR_STAT, v);
         chk({31'h0, v[`STAT_RDY]}, 32'h1);
         r = $random(seed);
         cnv(r[23:0]);
         frame_rd(cw(8'h39 + k[7:0], 2'd3, 1'b0, 1'b1), {8'h0, r[23:0]});
         frame_rd(cw(8'h38, 2'd3, 1'b0, 1'b0), {8'h0, r[23:0]});
      end
      results();
   end
endmodule
`default_nettype wire
